// file: core/pcw_cfg.svh
`ifndef PCW_CFG_SVH
`define PCW_CFG_SVH

// ************************************************************
// Config space placement (dword indices)
// ************************************************************
`define PCW_WIN_CAP_IDX 6'h10
`define PCW_WIN_BAR_IDX 6'h11
`define PCW_WIN_OFF_IDX 6'h12
`define PCW_WIN_LEN_IDX 6'h13
`define PCW_WIN_DATA_IDX 6'h14
`define PCW_VND_CAP_IDX 6'h15
`define PCW_VND_FMT_IDX 6'h16

// ************************************************************
// Capability header bytes
// ************************************************************
`define PCW_CAP_ID_VNDR 8'h09
`define PCW_WIN_CFG_TYPE 8'h05
`define PCW_WIN_CAP_LEN 8'h14
`define PCW_WIN_CAP_NEXT 8'h54
`define PCW_VND_CFG_TYPE 8'h09
`define PCW_VND_CAP_LEN 8'h08
`define PCW_VND_CAP_NEXT 8'h00
`define PCW_VND_FMT_DEFAULT 16'h5A5A

// ************************************************************
// Legacy block byte offsets
// ************************************************************
`define PCW_LG_DEV_FEAT 8'h00
`define PCW_LG_DRV_FEAT 8'h04
`define PCW_LG_RING_BASE 8'h08
`define PCW_LG_RING_DEPTH 8'h0C
`define PCW_LG_RING_SEL 8'h0E
`define PCW_LG_RING_KICK 8'h10
`define PCW_LG_DEV_STATE 8'h12
`define PCW_LG_INT_CAUSE 8'h13
`define PCW_LG_CFG_VEC 8'h14
`define PCW_LG_RING_VEC 8'h16
`define PCW_LG_DEVCFG_MSIX 8'h18
`define PCW_LG_DEVCFG_PLAIN 8'h14

// ************************************************************
// Fields and reset values
// ************************************************************
`define PCW_CAUSE_RING_BIT 0
`define PCW_CAUSE_CFG_BIT 1
`define PCW_NO_VECTOR 16'hFFFF
`define PCW_DEVCFG_BYTES 16

`endif

// file: core/pcw_pkg.sv
package pcw_pkg;

`include "pcw_cfg.svh"

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_BAR = 3'b010,
        ST_ANSWER = 3'b100
    } pcw_state_e;

    typedef logic [7:0] pcw_byte_t;

    typedef struct packed
    {
        pcw_state_e state;
        logic cfgAck;
        logic [31:0] cfgRdata;
        logic ioAck;
        logic [31:0] ioRdata;
        logic barReq;
        logic barWe;
        logic [3:0] barBe;
        logic [7:0] winBar;
        logic [31:0] winOffset;
        logic [31:0] winLength;
        logic [31:0] winData;
        logic [31:0] drvFeat;
        logic [31:0] ringBase;
        logic [15:0] ringSel;
        logic kick;
        logic [15:0] kickValue;
        logic [7:0] devState;
        logic [7:0] intCause;
        logic [15:0] cfgVec;
        logic [15:0] ringVec;
        logic [`PCW_DEVCFG_BYTES-1:0][7:0] devCfg;
        logic defeated;
    } pcw_regs_s;

endpackage

// file: core/pcw_vendor_cap.sv
`timescale 1ns/1ps
`include "pcw_cfg.svh"

module pcw_vendor_cap
#(
    // Arbitrary format code; never the transport's own vendor code
    parameter logic [15:0] VENDOR_FORMAT = `PCW_VND_FMT_DEFAULT
)
(
    // Lookup
    input wire logic [5:0] dwordIdx,
    output logic hit,
    output logic [31:0] data
);

    // Pure lookup: nothing here can carry a read side effect
    always_comb
    begin
        hit = 1'b1;
        data = 32'h0000_0000;
        case (dwordIdx)
            `PCW_VND_CAP_IDX:
                data = {`PCW_VND_CFG_TYPE, `PCW_VND_CAP_LEN, `PCW_VND_CAP_NEXT,
                    `PCW_CAP_ID_VNDR};
            `PCW_VND_FMT_IDX:
                data = {16'h0000, VENDOR_FORMAT};
            default:
                hit = 1'b0;
        endcase
    end

endmodule

// file: core/pcw_lane_mask.sv
`timescale 1ns/1ps

module pcw_lane_mask
(
    // Access size in bytes
    input wire logic [31:0] size,
    // Lanes used
    output logic [3:0] be,
    output logic [31:0] mask
);

    // Sizes other than 1, 2 or 4 enable no lane at all
    always_comb
    begin
        case (size)
            32'h0000_0001: be = 4'h1;
            32'h0000_0002: be = 4'h3;
            32'h0000_0004: be = 4'hF;
            default: be = 4'h0;
        endcase
        mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end

endmodule

// file: core/pcw_top.sv
`timescale 1ns/1ps
`include "pcw_cfg.svh"

// Contract
// - Vendor data capability spans a whole multiple of four bytes.
// - Reading the vendor data capability changes no state at all.
// - Window bar, size, offset and data fields are all read-write.
// - At least one configuration access capability is in the list.
// - Data write performs a bar write of the low size bytes.
// - Data read fetches size bytes from the bar into low bytes.
// - Transitional device maps the legacy block in I/O bar zero.
// - Device-specific bytes read the same at any access width.
// - Legacy header: three 32-bit, three 16-bit, two 8-bit fields, contiguous.
// - With MSI-X on, two 16-bit vector map fields follow the header.
// - Device-specific area starts at 24 with MSI-X, else at 20.
// - Device-specific area follows the header with no gap.
// - Feature bits 32 to 63 count as never acknowledged in legacy mode.
// - Non-transitional: zero byte write at 18 zeroes all bars, ignores writes.
// - Interrupt cause: bit 0 ring, bit 1 config change; read clears it.

module pcw_top
#(
    parameter bit TRANSITIONAL = 1'b1,
    // Arbitrary format code
    parameter logic [15:0] VENDOR_FORMAT = `PCW_VND_FMT_DEFAULT
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration space access
    input wire logic cfgReq,
    input wire logic cfgWe,
    input wire logic [5:0] cfgAddr,
    input wire logic [3:0] cfgBe,
    input wire logic [31:0] cfgWdata,
    output logic cfgAck,
    output logic [31:0] cfgRdata,
    // I/O bar zero access
    input wire logic ioReq,
    input wire logic ioWe,
    input wire logic [7:0] ioAddr,
    input wire logic [2:0] ioSize,
    input wire logic [31:0] ioWdata,
    output logic ioAck,
    output logic [31:0] ioRdata,
    // Window bar access
    output logic barReq,
    output logic barWe,
    output logic [7:0] barSel,
    output logic [31:0] barOffset,
    output logic [3:0] barBe,
    output logic [31:0] barWdata,
    input wire logic barAck,
    input wire logic [31:0] barRdata,
    // Device side
    input wire logic msixEnable,
    input wire logic [31:0] deviceFeature,
    input wire logic [15:0] ringDepth,
    input wire logic ringEvent,
    input wire logic configEvent,
    output logic [31:0] driverFeature,
    output logic [31:0] ringBase,
    output logic [15:0] ringSelect,
    output logic ringKick,
    output logic [15:0] ringKickValue,
    output logic [7:0] deviceState,
    output logic [7:0] interruptCause,
    output logic [15:0] configVector,
    output logic [15:0] ringVector,
    output logic legacyDefeated
);

    pcw_pkg::pcw_regs_s cur;
    pcw_pkg::pcw_regs_s next_cur;
    logic vndHit;
    logic [31:0] vndData;
    logic [3:0] winBe;
    logic [31:0] winMask;

    // ************************************************************
    // Read-only capability and lane helpers
    // ************************************************************
    pcw_vendor_cap #(.VENDOR_FORMAT(VENDOR_FORMAT)) vendorCap
    (
        .dwordIdx(cfgAddr),
        .hit(vndHit),
        .data(vndData)
    );

    pcw_lane_mask laneMask
    (
        .size(cur.winLength),
        .be(winBe),
        .mask(winMask)
    );

    function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] upd,
        input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[b*8 +: 8] = upd[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ************************************************************
    // Legacy byte read
    // ************************************************************
    function automatic logic [7:0] legacyByte(input pcw_pkg::pcw_regs_s r, input logic [7:0] a,
        input logic msix, input logic [31:0] devFeat, input logic [15:0] depth);
        logic [7:0] base;
        logic [7:0] rel;
        legacyByte = 8'h00;
        base = msix ? `PCW_LG_DEVCFG_MSIX : `PCW_LG_DEVCFG_PLAIN;
        rel = a - base;
        if (a < `PCW_LG_DRV_FEAT)
            legacyByte = devFeat[a[1:0]*8 +: 8];
        else if (a < `PCW_LG_RING_BASE)
            legacyByte = r.drvFeat[a[1:0]*8 +: 8];
        else if (a < `PCW_LG_RING_DEPTH)
            legacyByte = r.ringBase[a[1:0]*8 +: 8];
        else if (a < `PCW_LG_RING_SEL)
            legacyByte = depth[a[0]*8 +: 8];
        else if (a < `PCW_LG_RING_KICK)
            legacyByte = r.ringSel[a[0]*8 +: 8];
        else if (a < `PCW_LG_DEV_STATE)
            legacyByte = r.kickValue[a[0]*8 +: 8];
        else if (a == `PCW_LG_DEV_STATE)
            legacyByte = r.devState;
        else if (a == `PCW_LG_INT_CAUSE)
            legacyByte = r.intCause;
        else if (msix && a < `PCW_LG_RING_VEC)
            legacyByte = r.cfgVec[a[0]*8 +: 8];
        else if (msix && a < `PCW_LG_DEVCFG_MSIX)
            legacyByte = r.ringVec[a[0]*8 +: 8];
        else if (rel < 8'(`PCW_DEVCFG_BYTES))
            legacyByte = r.devCfg[rel[3:0]];
        return legacyByte;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic [7:0] a;
        logic [7:0] wb;
        logic [7:0] base;
        logic [7:0] rel;
        logic statusZero;
        logic msix;
        a = 8'h00;
        wb = 8'h00;
        rel = 8'h00;
        statusZero = 1'b0;
        msix = msixEnable;
        base = msix ? `PCW_LG_DEVCFG_MSIX : `PCW_LG_DEVCFG_PLAIN;
        next_cur = cur;
        next_cur.cfgAck = 1'b0;
        next_cur.ioAck = 1'b0;
        next_cur.barReq = 1'b0;
        next_cur.kick = 1'b0;

        // Configuration space side, window sequencing
        case (cur.state)
            pcw_pkg::ST_IDLE:
            begin
                if (cfgReq)
                begin
                    next_cur.cfgRdata = 32'h0000_0000;
                    next_cur.cfgAck = 1'b1;
                    case (cfgAddr)
                        `PCW_WIN_CAP_IDX:
                            next_cur.cfgRdata = {`PCW_WIN_CFG_TYPE, `PCW_WIN_CAP_LEN,
                                `PCW_WIN_CAP_NEXT, `PCW_CAP_ID_VNDR};
                        `PCW_WIN_BAR_IDX:
                        begin
                            if (cfgWe && cfgBe[0])
                                next_cur.winBar = cfgWdata[7:0];
                            next_cur.cfgRdata = {24'h000000, cur.winBar};
                        end
                        `PCW_WIN_OFF_IDX:
                        begin
                            if (cfgWe)
                                next_cur.winOffset = mergeBe(cur.winOffset, cfgWdata, cfgBe);
                            next_cur.cfgRdata = cur.winOffset;
                        end
                        `PCW_WIN_LEN_IDX:
                        begin
                            if (cfgWe)
                                next_cur.winLength = mergeBe(cur.winLength, cfgWdata, cfgBe);
                            next_cur.cfgRdata = cur.winLength;
                        end
                        `PCW_WIN_DATA_IDX:
                        begin
                            // Defeated device: reads answer zeroes, writes never reach the bar
                            if (cfgWe)
                                next_cur.winData = mergeBe(cur.winData, cfgWdata, cfgBe);
                            next_cur.cfgRdata = cfgWe ? next_cur.winData : 32'h0000_0000;
                            if (!cur.defeated)
                            begin
                                next_cur.cfgAck = 1'b0;
                                next_cur.barReq = 1'b1;
                                next_cur.barWe = cfgWe;
                                next_cur.barBe = winBe;
                                next_cur.state = pcw_pkg::ST_BAR;
                            end
                        end
                        default:
                            next_cur.cfgRdata = vndHit ? vndData : 32'h0000_0000;
                    endcase
                end
            end
            pcw_pkg::ST_BAR:
            begin
                if (barAck)
                begin
                    if (!cur.barWe)
                        next_cur.winData = barRdata & winMask;
                    next_cur.state = pcw_pkg::ST_ANSWER;
                end
            end
            pcw_pkg::ST_ANSWER:
            begin
                next_cur.cfgAck = 1'b1;
                next_cur.cfgRdata = cur.winData;
                next_cur.state = pcw_pkg::ST_IDLE;
            end
            default:
                next_cur.state = pcw_pkg::ST_IDLE;
        endcase

        // I/O bar zero side
        if (ioReq)
        begin
            next_cur.ioAck = 1'b1;
            next_cur.ioRdata = 32'h0000_0000;
            for (int i = 0; i < 4; i++)
            begin
                a = ioAddr + 8'(i);
                wb = ioWdata[i*8 +: 8];
                rel = a - base;
                if (3'(i) < ioSize && TRANSITIONAL && !cur.defeated)
                begin
                    if (!ioWe)
                    begin
                        next_cur.ioRdata[i*8 +: 8] = legacyByte(cur, a, msix, deviceFeature,
                            ringDepth);
                        if (a == `PCW_LG_INT_CAUSE)
                            next_cur.intCause = 8'h00;
                    end
                    else if (a >= `PCW_LG_DRV_FEAT && a < `PCW_LG_RING_BASE)
                        next_cur.drvFeat[a[1:0]*8 +: 8] = wb;
                    else if (a >= `PCW_LG_RING_BASE && a < `PCW_LG_RING_DEPTH)
                        next_cur.ringBase[a[1:0]*8 +: 8] = wb;
                    else if (a >= `PCW_LG_RING_SEL && a < `PCW_LG_RING_KICK)
                        next_cur.ringSel[a[0]*8 +: 8] = wb;
                    else if (a >= `PCW_LG_RING_KICK && a < `PCW_LG_DEV_STATE)
                    begin
                        next_cur.kickValue[a[0]*8 +: 8] = wb;
                        next_cur.kick = 1'b1;
                    end
                    else if (a == `PCW_LG_DEV_STATE)
                    begin
                        next_cur.devState = wb;
                        statusZero = (wb == 8'h00);
                    end
                    else if (msix && a >= `PCW_LG_CFG_VEC && a < `PCW_LG_RING_VEC)
                        next_cur.cfgVec[a[0]*8 +: 8] = wb;
                    else if (msix && a >= `PCW_LG_RING_VEC && a < `PCW_LG_DEVCFG_MSIX)
                        next_cur.ringVec[a[0]*8 +: 8] = wb;
                    else if (a >= base && rel < 8'(`PCW_DEVCFG_BYTES))
                        next_cur.devCfg[rel[3:0]] = wb;
                end
            end
            // Only a lone zero byte at the status offset trips the trap
            if (!TRANSITIONAL && ioWe && ioSize == 3'h1 && ioAddr == `PCW_LG_DEV_STATE
                && ioWdata[7:0] == 8'h00)
                next_cur.defeated = 1'b1;
        end

        // Zero status resets the legacy operating state
        if (statusZero)
        begin
            next_cur.drvFeat = 32'h0000_0000;
            next_cur.ringBase = 32'h0000_0000;
            next_cur.ringSel = 16'h0000;
            next_cur.devState = 8'h00;
            next_cur.intCause = 8'h00;
            next_cur.cfgVec = `PCW_NO_VECTOR;
            next_cur.ringVec = `PCW_NO_VECTOR;
        end

        // Events win over a clear in the same cycle
        if (ringEvent)
            next_cur.intCause[`PCW_CAUSE_RING_BIT] = 1'b1;
        if (configEvent)
            next_cur.intCause[`PCW_CAUSE_CFG_BIT] = 1'b1;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cur <= '0;
            cur.state <= pcw_pkg::ST_IDLE;
            cur.cfgVec <= `PCW_NO_VECTOR;
            cur.ringVec <= `PCW_NO_VECTOR;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ************************************************************
    // Outputs, all straight from the state register
    // ************************************************************
    assign cfgAck = cur.cfgAck;
    assign cfgRdata = cur.cfgRdata;
    assign ioAck = cur.ioAck;
    assign ioRdata = cur.ioRdata;
    assign barReq = cur.barReq;
    assign barWe = cur.barWe;
    assign barSel = cur.winBar;
    assign barOffset = cur.winOffset;
    assign barBe = cur.barBe;
    assign barWdata = cur.winData;
    assign driverFeature = cur.drvFeat;
    assign ringBase = cur.ringBase;
    assign ringSelect = cur.ringSel;
    assign ringKick = cur.kick;
    assign ringKickValue = cur.kickValue;
    assign deviceState = cur.devState;
    assign interruptCause = cur.intCause;
    assign configVector = cur.cfgVec;
    assign ringVector = cur.ringVec;
    assign legacyDefeated = cur.defeated;

endmodule

// file: test/pcw_top_sva.sv
`timescale 1ns/1ps

module pcw_top_sva
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Requests
    input wire logic cfgReq,
    input wire logic cfgWe,
    input wire logic [5:0] cfgAddr,
    input wire logic cfgAck,
    input wire logic ioReq,
    input wire logic ioWe,
    input wire logic [7:0] ioAddr,
    input wire logic ioAck,
    // Window bar
    input wire logic barReq,
    input wire logic barAck,
    // Device side
    input wire logic ringEvent,
    input wire logic configEvent,
    input wire logic [31:0] driverFeature,
    input wire logic [31:0] ringBase,
    input wire logic ringKick,
    input wire logic [7:0] interruptCause,
    input wire logic legacyDefeated
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_answer_late;
        ##2 cfgAck;
    endsequence
    sequence s_vendor_read;
        cfgReq && !cfgWe && !ioReq && !ringEvent && !configEvent
            && (cfgAddr == 6'h15 || cfgAddr == 6'h16);
    endsequence
    sequence s_cause_read;
        ioReq && !ioWe && ioAddr == 8'h13 && !ringEvent && !configEvent && !legacyDefeated;
    endsequence

    a_bar_ack_answer: assert property (barAck |-> s_answer_late)
        else $error("late window answer");
    a_io_answer_next: assert property (ioReq |=> ioAck)
        else $error("io access not answered");
    a_ring_cause_set: assert property (ringEvent |=> interruptCause[0])
        else $error("cause bit 0 not set");
    a_cfg_cause_set: assert property (configEvent |=> interruptCause[1])
        else $error("cause bit 1 not set");
    a_cause_read_clear: assert property (s_cause_read |=> interruptCause == 8'h00)
        else $error("cause not cleared by read");
    a_kick_write_pulse: assert property
        (ioReq && ioWe && ioAddr == 8'h10 && !legacyDefeated |=> ringKick)
        else $error("no kick pulse");
    a_vendor_read_quiet: assert property (s_vendor_read |=> $stable(driverFeature)
        && $stable(ringBase) && $stable(interruptCause))
        else $error("vendor read changed state");
    a_defeat_stays_set: assert property (legacyDefeated |=> legacyDefeated)
        else $error("defeated flag dropped");
    a_defeat_no_bar: assert property (legacyDefeated |-> !barReq)
        else $error("bar access while defeated");
endmodule

bind pcw_top pcw_top_sva u_sva (.clk(clk), .rst(rst), .cfgReq(cfgReq), .cfgWe(cfgWe),
    .cfgAddr(cfgAddr), .cfgAck(cfgAck), .ioReq(ioReq), .ioWe(ioWe), .ioAddr(ioAddr),
    .ioAck(ioAck), .barReq(barReq), .barAck(barAck), .ringEvent(ringEvent),
    .configEvent(configEvent), .driverFeature(driverFeature), .ringBase(ringBase),
    .ringKick(ringKick), .interruptCause(interruptCause), .legacyDefeated(legacyDefeated));

// file: test/pcw_bar_model.sv
`timescale 1ns/1ps

module pcw_bar_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Window bar access
    input wire logic barReq,
    input wire logic barWe,
    input wire logic [31:0] barOffset,
    input wire logic [3:0] barBe,
    input wire logic [31:0] barWdata,
    output logic barAck,
    output logic [31:0] barRdata,
    // Late answers when high
    input wire logic slow
);
    logic [7:0] mem [0:63];
    logic [31:0] q;
    logic [5:0] off;

    // Reads return all four lanes so the device's own masking is exercised
    initial
    begin
        {barAck, barRdata} = '0;
        forever
        begin
            @(posedge clk);
            if (barReq === 1'b1 && !rst)
            begin
                off = barOffset[5:0];
                for (int i = 0; i < 4; i++)
                begin
                    q[8*i +: 8] = mem[off + 6'(i)];
                    if (barWe && barBe[i])
                        mem[off + 6'(i)] = barWdata[8*i +: 8];
                end
                repeat (slow ? 5 : 0) @(posedge clk);
                barAck <= 1'b1;
                barRdata <= q;
                @(posedge clk);
                barAck <= 1'b0;
                // Released data must not look valid
                barRdata <= ~q;
            end
        end
    end
endmodule

// file: test/tb_pcw_top.sv
`timescale 1ns/1ps

module tb_pcw_top;
    localparam logic [15:0] VFMT = 16'h3C3C; // Arbitrary format code
    logic clk, rst, slow, cfgReq, cfgWe, cfgAck, ioReq, ioWe, ioAck;
    logic barReq, barWe, barAck, msixEnable, ringEvent, configEvent, ringKick, legacyDefeated;
    logic [5:0] cfgAddr;
    logic [3:0] cfgBe, barBe;
    logic [2:0] ioSize;
    logic [7:0] ioAddr, barSel, deviceState, interruptCause;
    logic [15:0] ringDepth, ringSelect, ringKickValue, configVector, ringVector;
    logic [31:0] cfgWdata, cfgRdata, ioWdata, ioRdata, barOffset, barWdata, barRdata;
    logic [31:0] deviceFeature, driverFeature, ringBase, rd;
    int errTotal, cmpCount, cycles;

    pcw_top #(.TRANSITIONAL(1'b1), .VENDOR_FORMAT(VFMT)) u_dut (.clk(clk), .rst(rst),
        .cfgReq(cfgReq), .cfgWe(cfgWe), .cfgAddr(cfgAddr), .cfgBe(cfgBe),
        .cfgWdata(cfgWdata), .cfgAck(cfgAck), .cfgRdata(cfgRdata), .ioReq(ioReq),
        .ioWe(ioWe), .ioAddr(ioAddr), .ioSize(ioSize), .ioWdata(ioWdata), .ioAck(ioAck),
        .ioRdata(ioRdata), .barReq(barReq), .barWe(barWe), .barSel(barSel),
        .barOffset(barOffset), .barBe(barBe), .barWdata(barWdata), .barAck(barAck),
        .barRdata(barRdata), .msixEnable(msixEnable), .deviceFeature(deviceFeature),
        .ringDepth(ringDepth), .ringEvent(ringEvent), .configEvent(configEvent),
        .driverFeature(driverFeature), .ringBase(ringBase), .ringSelect(ringSelect),
        .ringKick(ringKick), .ringKickValue(ringKickValue), .deviceState(deviceState),
        .interruptCause(interruptCause), .configVector(configVector),
        .ringVector(ringVector), .legacyDefeated(legacyDefeated));

    pcw_bar_model u_bar (.clk(clk), .rst(rst), .barReq(barReq), .barWe(barWe),
        .barOffset(barOffset), .barBe(barBe), .barWdata(barWdata), .barAck(barAck),
        .barRdata(barRdata), .slow(slow));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic giveVerdict;
        if (errTotal == 0 && cmpCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Far beyond the whole sequence
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errTotal++;
            giveVerdict;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One request pulse, then a bounded wait for its answer
    task automatic acc(input bit io, input logic we, input logic [7:0] a,
            input logic [3:0] w, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(negedge clk);
        if (io)
            {ioReq, ioWe, ioAddr, ioSize, ioWdata} = {1'b1, we, a, w[2:0], d};
        else
            {cfgReq, cfgWe, cfgAddr, cfgBe, cfgWdata} = {1'b1, we, a[5:0], w, d};
        @(negedge clk);
        {ioReq, cfgReq} = 2'b00;
        n = 0;
        while ((io ? ioAck : cfgAck) !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        check({31'h0, io ? ioAck : cfgAck}, 32'h1);
        q = io ? ioRdata : cfgRdata;
    endtask

    task automatic cfgw(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
        acc(1'b0, 1'b1, {2'b00, a}, be, d, rd);
    endtask

    task automatic cfgr(input logic [5:0] a, input logic [31:0] e);
        acc(1'b0, 1'b0, {2'b00, a}, 4'hF, 32'h0, rd);
        check(rd, e);
    endtask

    task automatic iow(input logic [7:0] a, input logic [2:0] s, input logic [31:0] d);
        acc(1'b1, 1'b1, a, {1'b0, s}, d, rd);
    endtask

    task automatic ior(input logic [7:0] a, input logic [2:0] s, input logic [31:0] e);
        logic [31:0] m;
        m = (s == 3'd4) ? 32'hFFFFFFFF : (s == 3'd2) ? 32'h0000FFFF : 32'h000000FF;
        acc(1'b1, 1'b0, a, {1'b0, s}, 32'h0, rd);
        check(rd & m, e);
    endtask

    task automatic t_layout;
        logic [7:0] a [4] = '{8'h04, 8'h08, 8'h0E, 8'h12};
        logic [2:0] s [4] = '{3'd4, 3'd4, 3'd2, 3'd1};
        logic [31:0] v [4] = '{32'h12345678, 32'h0ABCDEF1, 32'h00005A3C, 32'h0000000F};
        for (int i = 0; i < 4; i++)
            iow(a[i], s[i], v[i]);
        ior(8'h00, 3'd4, deviceFeature);
        iow(8'h0C, 3'd2, 32'h0000FFFF);
        ior(8'h0C, 3'd2, {16'h0, ringDepth});
        for (int i = 0; i < 4; i++)
            ior(a[i], s[i], v[i]);
        check({driverFeature ^ v[0], ringBase ^ v[1]} == 64'h0, 32'h1);
        check({ringSelect, deviceState}, {v[2][15:0], v[3][7:0]});
        iow(8'h10, 3'd2, 32'h00000007);
        check({16'h0, ringKickValue}, 32'h7);
    endtask

    task automatic t_msix;
        msixEnable = 1'b1;
        ior(8'h14, 3'd2, 32'h0000FFFF);
        iow(8'h14, 3'd2, 32'h00000123);
        iow(8'h16, 3'd2, 32'h00000456);
        iow(8'h18, 3'd4, 32'hCAFEF00D);
        check({configVector, ringVector}, 32'h01230456);
        ior(8'h18, 3'd4, 32'hCAFEF00D);
        msixEnable = 1'b0;
        ior(8'h14, 3'd4, 32'hCAFEF00D);
        ior(8'h15, 3'd1, 32'h000000F0);
        ior(8'h16, 3'd2, 32'h0000CAFE);
        iow(8'h17, 3'd1, 32'h00000011);
        msixEnable = 1'b1;
        ior(8'h18, 3'd4, 32'h11FEF00D);
    endtask

    task automatic t_cause;
        ior(8'h13, 3'd1, 32'h0);
        {ringEvent, configEvent} = 2'b10;
        @(negedge clk);
        {ringEvent, configEvent} = 2'b01;
        @(negedge clk);
        {ringEvent, configEvent} = 2'b00;
        check({24'h0, interruptCause}, 32'h3);
        ior(8'h13, 3'd1, 32'h3);
        ior(8'h13, 3'd1, 32'h0);
    endtask

    // Offset 0x10 is aligned for every size and lies in the modelled bar
    task automatic t_window;
        logic [31:0] m;
        cfgr(6'h10, 32'h05145409);
        cfgw(6'h11, 4'h1, 32'h00000002);
        cfgw(6'h12, 4'hF, 32'h00000010);
        for (int s = 1; s <= 4; s = s * 2)
        begin
            m = (s == 4) ? 32'hFFFFFFFF : (32'h1 << (8 * s)) - 32'h1;
            slow = (s == 2);
            cfgw(6'h13, 4'hF, 32'h4);
            cfgw(6'h14, 4'hF, 32'hFFFFFFFF);
            cfgw(6'h13, 4'hF, 32'(s));
            cfgw(6'h14, 4'hF, 32'h44332211);
            cfgr(6'h14, 32'h44332211 & m);
            cfgw(6'h13, 4'hF, 32'h4);
            cfgr(6'h14, (32'h44332211 & m) | ~m);
        end
        slow = 1'b0;
        cfgr(6'h11, 32'h2);
        check({24'h0, barSel}, 32'h2);
        cfgr(6'h12, 32'h10);
        cfgr(6'h13, 32'h4);
    endtask

    task automatic t_vendor;
        logic [31:0] f;
        f = driverFeature;
        cfgr(6'h15, 32'h09080009);
        check({30'h0, rd[17:16]}, 32'h0);
        cfgr(6'h16, {16'h0, VFMT});
        check(driverFeature, f);
    endtask

    initial
    begin
        {rst, slow, msixEnable, ringEvent, configEvent} = 5'b10000;
        {cfgReq, cfgWe, cfgAddr, cfgBe, cfgWdata} = '0;
        {ioReq, ioWe, ioAddr, ioSize, ioWdata} = '0;
        deviceFeature = 32'h89ABCDEF;
        ringDepth = 16'h0100;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        check({configVector, ringVector}, 32'hFFFFFFFF);
        t_layout;
        t_msix;
        t_cause;
        t_window;
        t_vendor;
        giveVerdict;
    end
endmodule
